/* core/dfc_pkg.sv */
// Overview of operation
// - Mode 00: disabled, S1 S3 closed on entry; all open after reset
// - Mode 01: non-inverting, S0 S3 closed
// - Mode 10: inverting, S1 S2 closed
// - Mode 11: zero-volt input, S1 S3 closed
// - Disabled: analog off, comparator forced low
// - Four switch bits, one closes each
// - Mode 01 gain 000 opens S2 S3
// - Three-bit gain code, bits 5 to 3
// - Debounce comparator with filter code length
// - Filtered output readable at bit 7
// - Eight-bit reference code drives DAC
// - Two-bit select picks one comm input
// - Calibration readback bit follows cancel mode
// - Cancel mode bits for amp, comparator
// - Reference select bits choose input polarity
// - Six-bit and five-bit trim fields held
// - Unimplemented bits read as zero
package dfc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE_CTRL   = 8'h00;
  localparam logic [7:0] OFS_GAIN_FILTER = 8'h04;
  localparam logic [7:0] OFS_REF_LEVEL   = 8'h08;
  localparam logic [7:0] OFS_AMP_TRIM    = 8'h0c;
  localparam logic [7:0] OFS_CMP_TRIM    = 8'h10;
  localparam logic [7:0] OFS_MISC_CTRL   = 8'h14;

  // Field positions
  localparam int MODE_LSB   = 6;
  localparam int GAIN_LSB   = 3;
  localparam int FLT_LSB    = 0;
  localparam int RDBK_BIT   = 7;
  localparam int OUT_BIT    = 7;
  localparam int CMODE_BIT  = 7;
  localparam int CREF_BIT   = 6;
  localparam int CCMODE_BIT = 6;
  localparam int CCREF_BIT  = 5;

  // Mode field codes
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_NINV = 2'h1;
  localparam logic [1:0] MODE_INV  = 2'h2;
  localparam logic [1:0] MODE_ZERO = 2'h3;

  // Switch patterns, bit n is switch n
  localparam logic [3:0] SW_OFF  = 4'ha;
  localparam logic [3:0] SW_NINV = 4'h9;
  localparam logic [3:0] SW_INV  = 4'h6;
  localparam logic [3:0] SW_ZERO = 4'ha;
  localparam logic [3:0] SW_BUF_MASK = 4'h3;

  // Reset value and AHB transfer code
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Filter clock divide from the crystal clock
  localparam int FLT_DIV = 4;
  localparam logic [1:0] PRE_LAST = 2'(FLT_DIV - 1);

  // Block state
  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] sw;
    logic [2:0] gain;
    logic [2:0] flt;
    logic [7:0] ref_lvl;
    logic       amp_cm;
    logic       amp_rs;
    logic [5:0] amp_trim;
    logic       cmp_cm;
    logic       cmp_rs;
    logic [4:0] cmp_trim;
    logic [1:0] in_sel;
    logic       demod_out;
    logic       irq;
    logic       cal_rb;
    logic [6:0] cnt;
    logic [1:0] pre;
    logic [3:0] sw_out;
    logic       en;
    logic       wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic       ready;
  } dfc_state_t;

  // Analog control bundle
  typedef struct packed {
    logic       en;
    logic [3:0] sw;
    logic [2:0] gain;
    logic [7:0] dac_code;
    logic [1:0] in_sel;
    logic       amp_cm;
    logic       amp_rs;
    logic [5:0] amp_trim;
    logic       cmp_cm;
    logic       cmp_rs;
    logic [4:0] cmp_trim;
  } dfc_analog_t;

endpackage : dfc_pkg

/* core/dfc_top.sv */
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dfc_top
  import dfc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Analog front end
  input  wire logic        cmp_raw_i,
  input  wire logic        amp_cal_i,
  output dfc_analog_t      analog_o,
  // Demodulated result
  output logic             demod_out_o,
  output logic             demod_irq_o
);

  dfc_state_t st;
  dfc_state_t st_next;

  // Switch pattern for a mode code
  function automatic logic [3:0] mode_switches(input logic [1:0] m);
    unique case (m)
      MODE_OFF:  mode_switches = SW_OFF;
      MODE_NINV: mode_switches = SW_NINV;
      MODE_INV:  mode_switches = SW_INV;
      MODE_ZERO: mode_switches = SW_ZERO;
    endcase
  endfunction : mode_switches

  // Filter periods needed for a code, 2^n - 1
  function automatic logic [6:0] flt_limit(input logic [2:0] code);
    flt_limit = 7'((8'h01 << code) - 8'h01);
  endfunction : flt_limit

  // Register read mux on a given state
  function automatic logic [31:0] read_word(input dfc_state_t s, input logic [7:0] a);
    read_word = 32'h0;
    unique case (a)
      OFS_MODE_CTRL:   read_word[7:0] = {s.mode, 2'h0, s.sw};
      OFS_GAIN_FILTER: read_word[7:0] = {s.demod_out, 1'h0, s.gain, s.flt};
      OFS_REF_LEVEL:   read_word[7:0] = s.ref_lvl;
      OFS_AMP_TRIM:    read_word[7:0] = {s.amp_cm, s.amp_rs, s.amp_trim};
      OFS_CMP_TRIM:    read_word[7:0] = {s.cal_rb, s.cmp_cm, s.cmp_rs, s.cmp_trim};
      OFS_MISC_CTRL:   read_word[7:0] = {6'h0, s.in_sel};
      default:         read_word = 32'h0;
    endcase
  endfunction : read_word

  logic       addr_ok;
  logic [7:0] wb;
  logic       cmp_eff;
  logic       tick;

  // Next state: bus writes, switches, filter, readback
  always_comb begin
    st_next = st;
    wb      = hwdata_i[7:0];
    addr_ok = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
    // Data phase of a write
    if (st.wr_pend) begin
      unique case (st.wr_addr)
        OFS_MODE_CTRL: begin
          st_next.mode = wb[MODE_LSB +: 2];
          // New mode loads its pattern, same mode takes the written individual bits
          if (wb[MODE_LSB +: 2] != st.mode) begin
            st_next.sw = mode_switches(wb[MODE_LSB +: 2]);
          end else begin
            st_next.sw = wb[3:0];
          end
        end
        OFS_GAIN_FILTER: begin
          st_next.gain = wb[GAIN_LSB +: 3];
          st_next.flt  = wb[FLT_LSB +: 3];
        end
        OFS_REF_LEVEL: st_next.ref_lvl = wb;
        OFS_AMP_TRIM: begin
          st_next.amp_cm   = wb[CMODE_BIT];
          st_next.amp_rs   = wb[CREF_BIT];
          st_next.amp_trim = wb[5:0];
        end
        OFS_CMP_TRIM: begin
          st_next.cmp_cm   = wb[CCMODE_BIT];
          st_next.cmp_rs   = wb[CCREF_BIT];
          st_next.cmp_trim = wb[4:0];
        end
        OFS_MISC_CTRL: st_next.in_sel = wb[1:0];
        default: st_next.mode = st.mode;
      endcase
    end
    // Address phase capture
    st_next.wr_pend = addr_ok && hwrite_i;
    st_next.wr_addr = haddr_i;
    st_next.ready   = 1'b1;
    // Enable and switch drive with buffer override
    st_next.en     = (st_next.mode != MODE_OFF);
    st_next.sw_out = st_next.sw;
    if (st_next.mode == MODE_NINV && st_next.gain == 3'h0) begin
      st_next.sw_out = st_next.sw & SW_BUF_MASK;
    end
    // Comparator forced low while disabled
    cmp_eff = st.en && cmp_raw_i;
    // Filter clock prescaler
    tick        = (st.pre == PRE_LAST);
    st_next.pre = st.en ? 2'(st.pre + 2'h1) : 2'h0;
    // Debounce filter
    if (!st.en) begin
      st_next.cnt       = 7'h0;
      st_next.demod_out = 1'b0;
    end else if (st.flt == 3'h0) begin
      st_next.cnt       = 7'h0;
      st_next.demod_out = cmp_eff;
    end else if (cmp_eff == st.demod_out) begin
      st_next.cnt = 7'h0;
    end else if (tick) begin
      if (7'(st.cnt + 7'h1) >= flt_limit(st.flt)) begin
        st_next.cnt       = 7'h0;
        st_next.demod_out = cmp_eff;
      end else begin
        st_next.cnt = 7'(st.cnt + 7'h1);
      end
    end
    // One-cycle trigger on each output change
    st_next.irq = (st_next.demod_out != st.demod_out);
    // Calibration readback source
    if (st.amp_cm) begin
      st_next.cal_rb = amp_cal_i;
    end else if (st.cmp_cm) begin
      st_next.cal_rb = cmp_raw_i;
    end else begin
      st_next.cal_rb = 1'b0;
    end
    // Read data from the state after any pending write
    st_next.rdata = (addr_ok && !hwrite_i) ? read_word(st_next, haddr_i) : 32'h0;
  end

  // State register
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= st_next;
    end
  end

  // Outputs straight from state
  assign hrdata_o          = st.rdata;
  assign hreadyout_o       = st.ready;
  assign hresp_o           = 1'b0;
  assign demod_out_o       = st.demod_out;
  assign demod_irq_o       = st.irq;
  assign analog_o.en       = st.en;
  assign analog_o.sw       = st.sw_out;
  assign analog_o.gain     = st.gain;
  assign analog_o.dac_code = st.ref_lvl;
  assign analog_o.in_sel   = st.in_sel;
  assign analog_o.amp_cm   = st.amp_cm;
  assign analog_o.amp_rs   = st.amp_rs;
  assign analog_o.amp_trim = st.amp_trim;
  assign analog_o.cmp_cm   = st.cmp_cm;
  assign analog_o.cmp_rs   = st.cmp_rs;
  assign analog_o.cmp_trim = st.cmp_trim;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  mode_off_sw_a: assert property ($changed(st.mode) && st.mode == MODE_OFF |-> analog_o.sw == SW_OFF)
    else $error("mode off switch pattern wrong");
  mode_ninv_sw_a: assert property ($changed(st.mode) && st.mode == MODE_NINV && st.gain != 3'h0
                                   |-> analog_o.sw == SW_NINV)
    else $error("non-inverting switch pattern wrong");
  mode_inv_sw_a: assert property ($changed(st.mode) && st.mode == MODE_INV |-> analog_o.sw == SW_INV)
    else $error("inverting switch pattern wrong");
  mode_zero_sw_a: assert property ($changed(st.mode) && st.mode == MODE_ZERO |-> analog_o.sw == SW_ZERO)
    else $error("zero input switch pattern wrong");
  off_forces_low_a: assert property (st.mode == MODE_OFF ##1 st.mode == MODE_OFF
                                     |-> !analog_o.en && !demod_out_o)
    else $error("disabled block not quiet");
  unity_buf_open_a: assert property (st.mode == MODE_NINV && st.gain == 3'h0 |-> analog_o.sw[3:2] == 2'h0)
    else $error("unity buffer switches not open");
  nofilter_follow_a: assert property (st.en && st.flt == 3'h0 && $past(st.en) && st.mode == $past(st.mode)
                                      |=> demod_out_o == $past(cmp_raw_i))
    else $error("unfiltered output does not follow comparator");
  irq_on_change_a: assert property ($changed(demod_out_o) |-> demod_irq_o ##1 (!demod_irq_o || $changed(demod_out_o)))
    else $error("trigger not a single pulse on change");
  rdbk_amp_sel_a: assert property (st.amp_cm && $past(st.amp_cm) |-> st.cal_rb == $past(amp_cal_i))
    else $error("readback does not show amplifier");
  unimpl_zero_a: assert property (hrdata_o[31:8] == 24'h0 && !hresp_o)
    else $error("upper read bits not zero");

  // Trigger only ever marks a real output change
  irq_only_change_a: assert property (demod_irq_o |-> $changed(demod_out_o))
    else $error("trigger without output change");

  // Analog blocks powered exactly while a demodulating mode is set
  en_follows_mode_a: assert property (analog_o.en == (st.mode != MODE_OFF))
    else $error("analog enable disagrees with mode");

  // Between filter ticks a filtered output cannot move
  flt_hold_tick_a: assert property (st.en && st.flt != 3'h0 && !tick |=> $stable(demod_out_o))
    else $error("filtered output moved between ticks");

  // Written reference code reaches the DAC
  ref_write_a: assert property ($past(st.wr_pend) && $past(st.wr_addr) == OFS_REF_LEVEL
                                |-> analog_o.dac_code == $past(hwdata_i[7:0]))
    else $error("reference code not applied");

  // Written gain code reaches the amplifier
  gain_write_a: assert property ($past(st.wr_pend) && $past(st.wr_addr) == OFS_GAIN_FILTER
                                 |-> analog_o.gain == $past(hwdata_i[5:3]))
    else $error("gain code not applied");

  // Written input select reaches the input mux
  insel_write_a: assert property ($past(st.wr_pend) && $past(st.wr_addr) == OFS_MISC_CTRL
                                  |-> analog_o.in_sel == $past(hwdata_i[1:0]))
    else $error("input select not applied");

  // Amplifier cancel controls and trim land together
  amp_trim_write_a: assert property ($past(st.wr_pend) && $past(st.wr_addr) == OFS_AMP_TRIM
                                     |-> {analog_o.amp_cm, analog_o.amp_rs, analog_o.amp_trim}
                                         == $past(hwdata_i[7:0]))
    else $error("amplifier trim not applied");

  // Comparator cancel controls and trim land together
  cmp_trim_write_a: assert property ($past(st.wr_pend) && $past(st.wr_addr) == OFS_CMP_TRIM
                                     |-> {analog_o.cmp_cm, analog_o.cmp_rs, analog_o.cmp_trim}
                                         == $past(hwdata_i[6:0]))
    else $error("comparator trim not applied");

  // Readback shows the comparator when only its cancel mode is on
  rdbk_cmp_sel_a: assert property (!$past(st.amp_cm) && $past(st.cmp_cm)
                                   |-> st.cal_rb == $past(cmp_raw_i))
    else $error("readback does not show comparator");

  // Readback idles low outside calibration
  rdbk_idle_a: assert property (!$past(st.amp_cm) && !$past(st.cmp_cm) |-> !st.cal_rb)
    else $error("readback not low in normal mode");

endmodule : dfc_top
`default_nettype wire

/* verification/dfc_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dfc_analog_model
  import dfc_pkg::*;
#(
  parameter int AMP_TH = 20,
  parameter int CMP_TH = 11
)(
  // Controls from the block
  input  wire dfc_analog_t analog_i,
  input  wire logic        sig_i,
  // Analog results
  output logic             cmp_raw_o,
  output logic             amp_cal_o
);
  // Amplifier output flips once trim crosses its offset
  assign amp_cal_o = analog_i.en & (32'(analog_i.amp_trim) >= AMP_TH);
  // Comparator low while disabled, trim compare in cancel mode
  assign cmp_raw_o = analog_i.en & (analog_i.cmp_cm ? (32'(analog_i.cmp_trim) >= CMP_TH) : sig_i);
endmodule : dfc_analog_model
`default_nettype wire

/* verification/dfc_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,a) begin checks_done++; if ((a)!==(e)) begin $display("unexpected %s exp %h got %h",n,e,a); miscompares++; end end
module dfc_tb_top
  import dfc_pkg::*;
;
  localparam int AMP_TH = 20;
  localparam int CMP_TH = 11;
  logic        mclk_i, arst_n_i, hsel, hwrite, sig, hrdy, cmp_raw, amp_cal, dout, irq;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, d;
  dfc_analog_t ana;
  int          miscompares, checks_done, cyc, v, m;
  logic [3:0]  sw_exp [4] = '{SW_NINV & SW_BUF_MASK, SW_INV, SW_ZERO, SW_OFF};

  dfc_top DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(), .cmp_raw_i(cmp_raw), .amp_cal_i(amp_cal), .analog_o(ana),
    .demod_out_o(dout), .demod_irq_o(irq));
  dfc_analog_model #(.AMP_TH(AMP_TH), .CMP_TH(CMP_TH)) FE (.analog_i(ana), .sig_i(sig),
    .cmp_raw_o(cmp_raw), .amp_cal_o(amp_cal));

  // Clock
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // Hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // One AHB single transfer
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd_o);
    @(posedge mclk_i);
    haddr  <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hsel   <= 1'b1;
    do @(posedge mclk_i); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk_i); while (hrdy !== 1'b1);
    rd_o = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    xfer(a, 1'b1, wd, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] rd_o);
    xfer(a, 1'b0, 32'h0, rd_o);
  endtask : rd

  task automatic settle();
    repeat (3) @(negedge mclk_i);
  endtask : settle

  // Trim sweep up then down, returns the average of the flip points
  task automatic sweep(input logic [7:0] a, input logic [7:0] cm, input int top, output int avg);
    int s, t;
    logic b;
    s = 0;
    for (int dir = 0; dir < 2; dir++) begin
      for (int k = 0; k <= top; k++) begin
        t = dir ? top - k : k;
        wr(a, {24'h0, cm | 8'(t)});
        settle();
        rd(OFS_CMP_TRIM, d);
        if (k == 0) b = d[7];
        else if (d[7] !== b) begin
          s += t;
          break;
        end
      end
    end
    avg = s / 2;
  endtask : sweep

  initial begin
    arst_n_i = 1'b0;
    hsel     = 1'b0;
    hwrite   = 1'b0;
    sig      = 1'b0;
    haddr    = 8'h00;
    htrans   = 2'h0;
    hwdata   = 32'h0;
    repeat (16) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    for (int r = 0; r < 6; r++) begin
      rd(8'(4 * r), d);
      `CHK("reset_val", 32'h0, d)
    end
    // Every mode code, from mode 00 after reset
    for (int i = 0; i < 4; i++) begin
      m = (i + 1) % 4;
      wr(OFS_MODE_CTRL, {24'h0, 2'(m), 6'h00});
      settle();
      `CHK("sw", sw_exp[i], ana.sw)
      `CHK("en", m != 0, ana.en)
      rd(OFS_MODE_CTRL, d);
      `CHK("mode_rd", {24'h0, 2'(m), 2'b00, (i == 0) ? SW_NINV : sw_exp[i]}, d)
    end
    // Debounce with no filter, then filter code 2
    wr(OFS_GAIN_FILTER, 32'h38);
    wr(OFS_MODE_CTRL, 32'h40);
    settle();
    `CHK("sw_gain", SW_NINV, ana.sw)
    `CHK("gain", 3'h7, ana.gain)
    @(posedge mclk_i) sig <= 1'b1;
    @(posedge mclk_i);
    @(negedge mclk_i);
    `CHK("irq_hi", 2'b11, {irq, dout})
    @(negedge mclk_i);
    `CHK("irq_lo", 2'b01, {irq, dout})
    rd(OFS_GAIN_FILTER, d);
    `CHK("out_rd", 32'hb8, d)
    wr(OFS_GAIN_FILTER, 32'h02);
    @(posedge mclk_i) sig <= 1'b0;
    repeat (8) @(negedge mclk_i);
    `CHK("flt_hold", 1'b1, dout)
    repeat (12) @(negedge mclk_i);
    `CHK("flt_done", 1'b0, dout)
    // Switch bits, unimplemented bits and plain registers
    wr(OFS_MODE_CTRL, 32'h75);
    settle();
    `CHK("sw_bits", 4'h1, ana.sw)
    rd(OFS_MODE_CTRL, d);
    `CHK("sw_rd", 32'h45, d)
    wr(OFS_GAIN_FILTER, 32'hff);
    rd(OFS_GAIN_FILTER, d);
    `CHK("gf_rd", 32'h3f, d)
    wr(OFS_REF_LEVEL, 32'ha5);
    wr(OFS_MISC_CTRL, 32'h03);
    wr(8'h18, 32'hff);
    settle();
    `CHK("dac", 8'ha5, ana.dac_code)
    `CHK("in_sel", 2'h3, ana.in_sel)
    rd(8'h18, d);
    `CHK("unmapped", 32'h0, d)
    // Disable forces the output low
    wr(OFS_GAIN_FILTER, 32'h00);
    @(posedge mclk_i) sig <= 1'b1;
    settle();
    `CHK("out_on", 1'b1, dout)
    wr(OFS_MODE_CTRL, 32'h00);
    settle();
    `CHK("out_off", 1'b0, dout)
    // Offset calibration, amplifier then comparator
    wr(OFS_MODE_CTRL, 32'hc0);
    sweep(OFS_AMP_TRIM, 8'hc0, 63, v);
    `CHK("amp_cm_rs", 2'b11, {ana.amp_cm, ana.amp_rs})
    `CHK("amp_vos", AMP_TH - 1, v)
    wr(OFS_AMP_TRIM, 32'(v));
    rd(OFS_AMP_TRIM, d);
    `CHK("amp_trim", 32'(v), d)
    `CHK("amp_trim_out", 6'(v), ana.amp_trim)
    sweep(OFS_CMP_TRIM, 8'h60, 31, v);
    `CHK("cmp_cm_rs", 2'b11, {ana.cmp_cm, ana.cmp_rs})
    `CHK("cmp_vos", CMP_TH - 1, v)
    wr(OFS_CMP_TRIM, 32'(v));
    rd(OFS_CMP_TRIM, d);
    `CHK("cmp_trim", 32'(v), d)
    `CHK("cmp_trim_out", 5'(v), ana.cmp_trim)
    end_of_test();
  end
endmodule : dfc_tb_top
`default_nettype wire
